// ---- design/canopen_identity_error_objects.sv ----
// Identity and error objects of a field-bus I/O node's object directory.
// Assumes a service data layer that hands over whole expedited requests,
// one per cycle at most, with byte lane 0 being the first byte on the bus.
`timescale 1ns/1ps
module canopen_identity_error_objects
  import object_dir_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Service data request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_index_in,
  input wire logic [7:0] req_subindex_in,
  input wire logic [31:0] req_data_in,
  // Service data answer
  output logic resp_valid_out,
  output logic resp_abort_out,
  output logic [31:0] resp_data_out,
  // Fitted standard I/O module kinds
  input wire logic dig_in_present_in,
  input wire logic dig_out_present_in,
  input wire logic ana_in_present_in,
  input wire logic ana_out_present_in,
  // Error message events from the node
  input wire logic err_valid_in,
  input wire logic [15:0] err_code_in,
  input wire logic [15:0] err_add_in,
  input wire logic err_comm_in,
  input wire logic err_maker_in,
  // State seen by the rest of the node
  output logic [7:0] error_flags_out,
  output logic [3:0] history_count_out,
  output logic [10:0] sync_cob_id_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [3:0] type_flags_reg;
  logic [7:0] error_flags_reg;
  logic [10:0] sync_id_reg;
  logic resp_valid_reg;
  logic resp_abort_reg;
  logic [31:0] resp_data_reg;
  logic [3:0] count_reg;
  logic [3:0] hist_count;
  logic [31:0] hist_entry;
  logic [31:0] device_type_word;
  logic [31:0] hist_new_entry;
  logic hist_clear;
  logic sync_write;
  outcome_t outcome;
  logic [31:0] answer_word;

  // ****************************************************************
  // Device type
  // ****************************************************************

  // standard modules only
  // Only standard I/O kinds drive the flags; special modules have no input
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      type_flags_reg <= 4'h0;
    else
    begin
      type_flags_reg[INFO_DIG_IN_BIT] <= dig_in_present_in;
      type_flags_reg[INFO_DIG_OUT_BIT] <= dig_out_present_in;
      type_flags_reg[INFO_ANA_IN_BIT] <= ana_in_present_in;
      type_flags_reg[INFO_ANA_OUT_BIT] <= ana_out_present_in;
    end
  end

  always_comb
  begin
    device_type_word = 32'h00000000;
    device_type_word[DT_PROFILE_LSB +: 16] = DEVICE_PROFILE;
    device_type_word[DT_INFO_LSB +: 4] = type_flags_reg;
  end

  // ****************************************************************
  // Error flags
  // ****************************************************************

  // sticky until reset
  // Flags gather every error raised since the last reset
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      error_flags_reg <= ERROR_FLAGS_RESET;
    else if (err_valid_in)
    begin
      error_flags_reg[GENERIC_BIT] <= 1'b1;
      if (err_comm_in)
        error_flags_reg[COMM_BIT] <= 1'b1;
      if (err_maker_in)
        error_flags_reg[MAKER_BIT] <= 1'b1;
    end
  end

  // ****************************************************************
  // Error history
  // ****************************************************************

  always_comb
  begin
    hist_new_entry = 32'h00000000;
    hist_new_entry[ENTRY_CODE_LSB +: 16] = err_code_in;
    hist_new_entry[ENTRY_ADD_LSB +: 16] = err_add_in;
  end

  assign hist_clear = req_valid_in && req_write_in
    && req_index_in == IDX_ERROR_HISTORY
    && req_subindex_in == 8'h00 && req_data_in == 32'h00000000;

  error_history_store u_history
  (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .push_in(err_valid_in),
    .entry_in(hist_new_entry),
    .clear_in(hist_clear),
    .rd_sel_in(req_subindex_in[3:0]),
    .count_out(hist_count),
    .rd_entry_out(hist_entry)
  );

  // Registered copy of the count for the output pin
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      count_reg <= HISTORY_COUNT_RESET;
    else
      count_reg <= hist_count;
  end

  // ****************************************************************
  // Sync identifier
  // ****************************************************************

  assign sync_write = req_valid_in && req_write_in
    && req_index_in == IDX_SYNC_ID && req_subindex_in == 8'h00
    && !req_data_in[SYNC_PRODUCER_BIT];

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      sync_id_reg <= SYNC_ID_RESET;
    else if (sync_write)
      sync_id_reg <= req_data_in[SYNC_ID_WIDTH - 1:0];
  end

  // ****************************************************************
  // Request decode
  // ****************************************************************

  always_comb
  begin
    outcome = OUTCOME_OK;
    answer_word = 32'h00000000;
    case (req_index_in)
      IDX_DEVICE_TYPE:
      begin
        if (req_subindex_in != 8'h00)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_NO_SUBINDEX;
        end
        else if (req_write_in)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_READ_ONLY;
        end
        else
          answer_word = device_type_word;
      end
      IDX_ERROR_FLAGS:
      begin
        if (req_subindex_in != 8'h00)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_NO_SUBINDEX;
        end
        else if (req_write_in)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_READ_ONLY;
        end
        else
          answer_word = {24'h000000, error_flags_reg};
      end
      IDX_ERROR_HISTORY:
      begin
        if (req_subindex_in == 8'h00)
        begin
          if (req_write_in && req_data_in != 32'h00000000)
          begin
            outcome = OUTCOME_ABORT;
            answer_word = ABORT_BAD_VALUE;
          end
          else if (!req_write_in)
            answer_word = {28'h0000000, hist_count};
        end
        else if (req_subindex_in > {4'h0, hist_count})
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_NO_SUBINDEX;
        end
        else if (req_write_in)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_READ_ONLY;
        end
        else
          answer_word = hist_entry;
      end
      IDX_SYNC_ID:
      begin
        if (req_subindex_in != 8'h00)
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_NO_SUBINDEX;
        end
        else if (req_write_in && req_data_in[SYNC_PRODUCER_BIT])
        begin
          outcome = OUTCOME_ABORT;
          answer_word = ABORT_BAD_VALUE;
        end
        else if (!req_write_in)
          answer_word = {21'h00000, sync_id_reg};
      end
      default:
      begin
        outcome = OUTCOME_ABORT;
        answer_word = ABORT_NO_OBJECT;
      end
    endcase
  end

  // ****************************************************************
  // Answer register
  // ****************************************************************

  // lane 0 is sent first
  // One answer per request, one cycle after it is taken
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      resp_valid_reg <= 1'b0;
      resp_abort_reg <= 1'b0;
      resp_data_reg <= 32'h00000000;
    end
    else
    begin
      resp_valid_reg <= req_valid_in;
      resp_abort_reg <= req_valid_in && outcome == OUTCOME_ABORT;
      if (req_valid_in)
        resp_data_reg <= answer_word;
    end
  end

  assign resp_valid_out = resp_valid_reg;
  assign resp_abort_out = resp_abort_reg;
  assign resp_data_out = resp_data_reg;
  assign error_flags_out = error_flags_reg;
  assign history_count_out = count_reg;
  assign sync_cob_id_out = sync_id_reg;

endmodule : canopen_identity_error_objects

// ---- pkg/object_dir_pkg.sv ----
// Object directory constants for the identity and error object bank.
// Assumes a single 25 MHz core clock and word-wide service data requests.
package object_dir_pkg;

  // ****************************************************************
  // Object indices
  // ****************************************************************
  localparam logic [15:0] IDX_DEVICE_TYPE = 16'h1000;
  localparam logic [15:0] IDX_ERROR_FLAGS = 16'h1001;
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_SYNC_ID = 16'h1005;

  // ****************************************************************
  // Device type layout
  // ****************************************************************
  localparam logic [15:0] DEVICE_PROFILE = 16'h0191;
  localparam int DT_PROFILE_LSB = 0;
  localparam int DT_INFO_LSB = 16;
  localparam int INFO_DIG_IN_BIT = 0;
  localparam int INFO_DIG_OUT_BIT = 1;
  localparam int INFO_ANA_IN_BIT = 2;
  localparam int INFO_ANA_OUT_BIT = 3;

  // ****************************************************************
  // Error flags layout
  // ****************************************************************
  localparam logic [7:0] ERROR_FLAGS_RESET = 8'h00;
  localparam int GENERIC_BIT = 0;
  localparam int COMM_BIT = 4;
  localparam int MAKER_BIT = 7;

  // ****************************************************************
  // Error history
  // ****************************************************************
  localparam int HISTORY_DEPTH = 10;
  localparam logic [3:0] HISTORY_MAX = 4'hA;
  localparam logic [3:0] HISTORY_COUNT_RESET = 4'h0;
  localparam int ENTRY_CODE_LSB = 0;
  localparam int ENTRY_ADD_LSB = 16;

  // ****************************************************************
  // Sync identifier layout
  // ****************************************************************
  localparam logic [10:0] SYNC_ID_RESET = 11'h080;
  localparam int SYNC_ID_WIDTH = 11;
  localparam int SYNC_PRODUCER_BIT = 30;
  localparam int SYNC_COMPAT_BIT = 31;

  // ****************************************************************
  // Transfer abort codes
  // ****************************************************************
  localparam logic [31:0] ABORT_READ_ONLY = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h06020000;
  localparam logic [31:0] ABORT_NO_SUBINDEX = 32'h06090011;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h06090030;

  // Request handling outcome
  typedef enum logic [1:0] {
    OUTCOME_OK,
    OUTCOME_ABORT
  } outcome_t;

endpackage : object_dir_pkg

// ---- design/error_history_store.sv ----
// Ten-deep shifting error history with newest entry at position 1.
// Assumes push and clear come from logic on the same core clock.
`timescale 1ns/1ps
module error_history_store
  import object_dir_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic push_in,
  input wire logic [31:0] entry_in,
  input wire logic clear_in,
  input wire logic [3:0] rd_sel_in,
  output logic [3:0] count_out,
  output logic [31:0] rd_entry_out
);

  logic [31:0] entry_reg [HISTORY_DEPTH];
  logic [3:0] count_reg;

  // ****************************************************************
  // Entry shifting
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < HISTORY_DEPTH; g++)
    begin : g_slot
      // Newest at slot 0, older ones move up; the last one drops
      always_ff @(posedge core_clk_in)
      begin
        if (rst_in)
          entry_reg[g] <= 32'h00000000;
        else if (push_in)
          entry_reg[g] <= (g == 0) ? entry_in : entry_reg[(g == 0) ? 0 : g - 1];
      end
    end
  endgenerate

  // Count saturates at ten; a push in the clear cycle survives
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      count_reg <= HISTORY_COUNT_RESET;
    else if (push_in && clear_in)
      count_reg <= 4'h1;
    else if (clear_in)
      count_reg <= HISTORY_COUNT_RESET;
    else if (push_in && count_reg != HISTORY_MAX)
      count_reg <= count_reg + 4'h1;
  end

  assign count_out = count_reg;

  // Position 1..10 maps to slot 0..9
  always_comb
  begin
    rd_entry_out = 32'h00000000;
    if (rd_sel_in != 4'h0 && rd_sel_in <= HISTORY_MAX)
      rd_entry_out = entry_reg[rd_sel_in - 4'h1];
  end

endmodule : error_history_store

// ---- verif/canopen_identity_error_objects_monitor.sv ----
// Checker for the identity and error object bank.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module object_bank_monitor
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [15:0] req_index_in,
  input wire logic [7:0] req_subindex_in,
  input wire logic err_valid_in,
  input wire logic err_comm_in,
  input wire logic err_maker_in,
  input wire logic resp_valid_out,
  input wire logic resp_abort_out,
  input wire logic [31:0] resp_data_out,
  input wire logic [7:0] error_flags_out,
  input wire logic [3:0] history_count_out,
  input wire logic [10:0] sync_cob_id_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_answer_next_cycle: assert property
    (req_valid_in |=> resp_valid_out)
    else $error("no answer after request");
  a_no_stray_answer: assert property
    (!req_valid_in |=> !resp_valid_out)
    else $error("answer without request");
  a_generic_flag_set: assert property
    (err_valid_in |=> error_flags_out[0])
    else $error("generic flag not set");
  a_comm_flag_set: assert property
    (err_valid_in && err_comm_in |=> error_flags_out[4])
    else $error("comm flag not set");
  a_maker_flag_set: assert property
    (err_valid_in && err_maker_in |=> error_flags_out[7])
    else $error("maker flag not set");
  a_reserved_flags_zero: assert property
    ((error_flags_out & 8'h6E) == 8'h00)
    else $error("reserved flag set");
  a_history_bound: assert property
    (history_count_out <= 4'hA)
    else $error("history count above ten");
  a_reset_defaults: assert property
    ($fell(rst_in) |-> sync_cob_id_out == 11'h080
    && history_count_out == 4'h0 && error_flags_out == 8'h00)
    else $error("bad state after reset");
  // A bad sub-index on these objects aborts with another code
  a_read_only_refused: assert property
    (req_valid_in && req_write_in && req_subindex_in == 8'h00
    && req_index_in inside {16'h1000, 16'h1001}
    |=> resp_abort_out && resp_data_out == 32'h06010002)
    else $error("read-only write not refused");
  // Main scenarios reached
  c_error_taken: cover property (err_valid_in);
  c_write_refused: cover property (req_valid_in && req_write_in ##1 resp_abort_out);
  c_history_full: cover property (history_count_out == 4'hA);
endmodule : object_bank_monitor

bind canopen_identity_error_objects object_bank_monitor object_bank_monitor_i (
  .core_clk_in, .rst_in, .req_valid_in, .req_write_in, .req_index_in,
  .req_subindex_in,
  .err_valid_in, .err_comm_in, .err_maker_in, .resp_valid_out, .resp_abort_out,
  .resp_data_out, .error_flags_out, .history_count_out, .sync_cob_id_out);

// ---- verif/sdo_master_model.sv ----
// Network master model issuing service data requests to the object bank.
// Assumes answers come one cycle after the edge that takes a request.
`timescale 1ns/1ps
module sdo_master_model
(
  input wire logic core_clk_in,
  output logic req_valid_out,
  output logic req_write_out,
  output logic [15:0] req_index_out,
  output logic [7:0] req_subindex_out,
  output logic [31:0] req_data_out,
  input wire logic resp_valid_in,
  input wire logic resp_abort_in,
  input wire logic [31:0] resp_data_in
);
  // ****************************************************************
  // Transfers
  // ****************************************************************
  // Idle bus at time zero
  initial
  begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_index_out = 16'h0000;
    req_subindex_out = 8'h00;
    req_data_out = 32'h00000000;
  end

  task automatic xfer(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd,
    output logic seen, output logic ab, output logic [31:0] rd);
    @(posedge core_clk_in);
    req_valid_out <= 1'b1;
    req_write_out <= wr;
    req_index_out <= idx;
    req_subindex_out <= sub;
    req_data_out <= wd;
    @(posedge core_clk_in);
    // Released lines show junk, not the old request
    req_valid_out <= 1'b0;
    req_write_out <= ~wr;
    req_index_out <= ~idx;
    req_subindex_out <= ~sub;
    req_data_out <= ~wd;
    // Answer stands for the cycle after the taking edge
    @(posedge core_clk_in);
    seen = resp_valid_in;
    ab = resp_abort_in;
    rd = resp_data_in;
  endtask : xfer

  task automatic clear_history(output logic seen, ab);
    logic [31:0] rd;
    xfer(1'b1, 16'h1003, 8'h00, 32'h00000000, seen, ab, rd);
  endtask : clear_history
endmodule : sdo_master_model

// ---- verif/test_canopen_identity_error_objects.sv ----
// Self-checking bench for the identity and error object bank.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) check(nm, 32'(ex), 32'(got))
module test_canopen_identity_error_objects
  import object_dir_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid, req_write, resp_valid, resp_abort;
  logic [15:0] req_index, err_code = 16'h0000, err_add = 16'h0000;
  logic [7:0] req_subindex, error_flags;
  logic [31:0] req_data, resp_data;
  logic [3:0] present = 4'h0, history_count;
  logic err_valid = 1'b0, err_comm = 1'b0, err_maker = 1'b0;
  logic [10:0] sync_id;
  int n_mismatch = 0, tests_run = 0;

  // ****************************************************************
  // Structure and helpers
  // ****************************************************************
  // 25 MHz clock
  always #20 core_clk_in = ~core_clk_in;

  canopen_identity_error_objects canopen_identity_error_objects_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_index_in(req_index),
    .req_subindex_in(req_subindex), .req_data_in(req_data),
    .resp_valid_out(resp_valid), .resp_abort_out(resp_abort),
    .resp_data_out(resp_data), .dig_in_present_in(present[0]),
    .dig_out_present_in(present[1]), .ana_in_present_in(present[2]),
    .ana_out_present_in(present[3]), .err_valid_in(err_valid),
    .err_code_in(err_code), .err_add_in(err_add), .err_comm_in(err_comm),
    .err_maker_in(err_maker), .error_flags_out(error_flags),
    .history_count_out(history_count), .sync_cob_id_out(sync_id));

  sdo_master_model sdo_master_model_i (
    .core_clk_in(core_clk_in), .req_valid_out(req_valid),
    .req_write_out(req_write), .req_index_out(req_index),
    .req_subindex_out(req_subindex), .req_data_out(req_data),
    .resp_valid_in(resp_valid), .resp_abort_in(resp_abort),
    .resp_data_in(resp_data));

  task automatic check(input string nm, input logic [31:0] ex, got);
    tests_run++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic do_reset;
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
  endtask : do_reset

  // One transfer judged on answer, refusal and data
  task automatic do_req(input logic wr, input logic [15:0] idx,
    input logic [7:0] sub, input logic [31:0] wd, input logic ex_ab,
    input logic [31:0] ex_d, input string nm);
    logic seen, ab;
    logic [31:0] rd;
    sdo_master_model_i.xfer(wr, idx, sub, wd, seen, ab, rd);
    `CHK({nm, "_answer"}, 1'b1, seen);
    `CHK({nm, "_abort"}, ex_ab, ab);
    `CHK(nm, ex_d, rd);
  endtask : do_req

  task automatic push_err(input logic [15:0] code, add, input logic cm, mk);
    @(posedge core_clk_in);
    err_valid <= 1'b1;
    err_code <= code;
    err_add <= add;
    err_comm <= cm;
    err_maker <= mk;
    @(posedge core_clk_in);
    err_valid <= 1'b0;
  endtask : push_err

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_fresh;
    do_req(0, IDX_ERROR_HISTORY, 0, 0, 0, 0, "count0");
    do_req(0, IDX_ERROR_HISTORY, 1, 0, 1, ABORT_NO_SUBINDEX, "sub1");
    do_req(0, IDX_ERROR_FLAGS, 0, 0, 0, 0, "flags0");
    do_req(0, IDX_SYNC_ID, 0, 0, 0, 32'h80, "sync0");
    do_req(0, 16'h1002, 0, 0, 1, ABORT_NO_OBJECT, "no_obj");
  endtask : t_fresh

  task automatic t_devtype;
    logic [3:0] pat [4] = '{4'h5, 4'h0, 4'hA, 4'hF};
    for (int i = 0; i < 4; i++)
    begin
      present <= pat[i];
      do_reset();
      do_req(0, IDX_DEVICE_TYPE, 0, 0, 0,
        {12'h000, pat[i], 16'h0191}, "dtype");
    end
    do_req(1, IDX_DEVICE_TYPE, 0, 1, 1, ABORT_READ_ONLY, "dtype_wr");
  endtask : t_devtype

  task automatic t_history;
    logic seen, ab;
    for (int i = 1; i <= 11; i++)
      push_err(16'(i), 16'(16'hA0 + i), i == 3, i == 11);
    do_req(0, IDX_ERROR_HISTORY, 0, 0, 0, 10, "count10");
    `CHK("count_port", 4'hA, history_count);
    do_req(0, IDX_ERROR_HISTORY, 1, 0, 0,
      32'h00AB000B, "newest");
    do_req(0, IDX_ERROR_HISTORY, 10, 0, 0,
      32'h00A20002, "oldest");
    do_req(0, IDX_ERROR_HISTORY, 11, 0, 1, ABORT_NO_SUBINDEX, "sub11");
    do_req(1, IDX_ERROR_HISTORY, 1, 5, 1, ABORT_READ_ONLY, "entry_wr");
    do_req(1, IDX_ERROR_FLAGS, 0, 0, 1, ABORT_READ_ONLY, "flags_wr");
    do_req(0, IDX_ERROR_FLAGS, 0, 0, 0, 32'h91, "flags");
    do_req(1, IDX_ERROR_HISTORY, 0, 5, 1, ABORT_BAD_VALUE, "clear5");
    sdo_master_model_i.clear_history(seen, ab);
    `CHK("clear_abort", 1'b0, ab);
    do_req(0, IDX_ERROR_HISTORY, 0, 0, 0, 0, "cleared");
    do_req(0, IDX_ERROR_HISTORY, 1, 0, 1, ABORT_NO_SUBINDEX, "gone");
    `CHK("flags_kept", 8'h91, error_flags);
  endtask : t_history

  task automatic t_sync;
    do_req(1, IDX_SYNC_ID, 0, 32'h80000081, 0, 0, "sync_wr");
    do_req(0, IDX_SYNC_ID, 0, 0, 0, 32'h81, "sync_rd");
    `CHK("sync_port", 11'h081, sync_id);
    do_req(1, IDX_SYNC_ID, 0, 32'h40000090, 1, ABORT_BAD_VALUE, "prod");
    do_req(0, IDX_SYNC_ID, 0, 0, 0, 32'h81, "sync_kept");
  endtask : t_sync

  task automatic t_reset_clears;
    push_err(16'h1234, 16'h5678, 1'b1, 1'b1);
    do_reset();
    `CHK("flags_rst", 8'h00, error_flags);
    `CHK("count_rst", 4'h0, history_count);
    do_req(0, IDX_ERROR_HISTORY, 0, 0, 0, 0, "count_rst");
    do_req(0, IDX_SYNC_ID, 0, 0, 0, 32'h80, "sync_rst");
  endtask : t_reset_clears

  // Main sequence
  initial
  begin
    do_reset();
    t_fresh();
    t_devtype();
    t_history();
    t_sync();
    t_reset_clears();
    summarize();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (5000) @(posedge core_clk_in);
    n_mismatch++;
    summarize();
  end
endmodule : test_canopen_identity_error_objects
